// file: design/utl2_pkg.sv
package utl2_pkg;

	// ============================================================
	// Widths
	localparam int unsigned BYTE_W  = 8;
	localparam int unsigned ADDR_W  = 4;
	localparam int unsigned CNT_W   = 6;
	localparam int unsigned SYNC_W  = 3;
	localparam int unsigned WORD_W  = ADDR_W + 1 + BYTE_W;
	localparam int unsigned FIFO_D  = 2;

	// ============================================================
	// Word layout: {phy address, start flag, byte}
	localparam int unsigned BYTE_LSB = 0;
	localparam int unsigned SOC_BIT  = BYTE_W;
	localparam int unsigned PHY_LSB  = BYTE_W + 1;

	// ============================================================
	// Cell and polling figures
	localparam logic [CNT_W-1:0]  CELL_BYTES = 6'h35;
	localparam logic [CNT_W-1:0]  CNT_FIRST  = 6'h01;
	localparam logic [CNT_W-1:0]  CNT_ZERO   = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO  = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_ONE   = 4'h1;
	localparam logic [ADDR_W-1:0] LAST_12PHY = 4'hB;
	localparam logic [ADDR_W-1:0] LAST_15PHY = 4'hE;
	localparam logic [SYNC_W-1:0] SYNC_ZERO  = 3'h0;
	localparam logic [WORD_W-1:0] WORD_ZERO  = 13'h0000;

	// ============================================================
	// Link-side sequencer
	typedef enum logic [2:0] {
		ST_POLL = 3'h1,
		ST_SEL  = 3'h2,
		ST_XFER = 3'h4
	} utl2_state_t;

	// A synchronised level counts once the second and third stages agree
	function automatic logic utl2_agree(input logic [SYNC_W-1:0] s);
		return s[1] == s[2];
	endfunction

	function automatic logic [ADDR_W-1:0] utl2_next_addr(input logic [ADDR_W-1:0] a, input logic mode15);
		logic [ADDR_W-1:0] last;
		last = mode15 ? LAST_15PHY : LAST_12PHY;
		return (a >= last) ? ADDR_ZERO : a + ADDR_ONE;
	endfunction

endpackage

// file: design/utl2_stream_if.sv
`timescale 1ns/1ps
interface utl2_stream_if;
	import utl2_pkg::*;
	logic                valid;
	logic                ready;
	logic [WORD_W-1:0]   data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// file: design/utl2_buf2.sv
`timescale 1ns/1ps
module utl2_buf2 (
	input  wire logic     sys_clk,
	input  wire logic     rst,
	utl2_stream_if.snk    up,
	utl2_stream_if.src    dn
);
	import utl2_pkg::*;

	// ============================================================
	// Two-entry buffer; a stalled reader backs up into the crossing
	logic [WORD_W-1:0] mem_q [FIFO_D];
	logic [WORD_W-1:0] mem_d [FIFO_D];
	logic              wp_q, wp_d, rp_q, rp_d;
	logic [1:0]        cnt_q, cnt_d;
	logic              push, pop;

	assign up.ready = (cnt_q != 2'h2);
	assign dn.valid = (cnt_q != 2'h0);
	assign dn.data  = mem_q[rp_q];
	assign push     = up.valid && up.ready;
	assign pop      = dn.valid && dn.ready;

	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wp_q] = up.data;
			wp_d        = ~wp_q;
		end
		if (pop) begin
			rp_d = ~rp_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		mem_q <= mem_d;
		if (rst) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // utl2_buf2

// file: design/utl2_rx_port.sv
// Functional notes
// - Byte-wide cell data, bit 7 most significant
// - Port samples inputs on its own clock's rise
// - Low enable means byte accepted next cycle
// - Four-bit PHY select address, bit 3 most significant
// - 12-PHY and 15-PHY modes, both byte-wide
`timescale 1ns/1ps
module utl2_rx_port (
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	input  wire logic                            mode_15phy,
	input  wire logic                            port_link_clock,
	output logic     [utl2_pkg::ADDR_W-1:0]      rx_phy_select_addr,
	output logic                                 rx_accept_n,
	input  wire logic [utl2_pkg::BYTE_W-1:0]     rx_cell_byte_in,
	input  wire logic                            rx_cell_start_flag,
	input  wire logic                            rx_cell_available,
	output logic                                 cell_valid,
	input  wire logic                            cell_ready,
	output logic     [utl2_pkg::BYTE_W-1:0]      cell_byte,
	output logic                                 cell_start,
	output logic     [utl2_pkg::ADDR_W-1:0]      cell_phy
);
	import utl2_pkg::*;

	// ============================================================
	// Link domain: reset and mode brought over from sys_clk
	logic [SYNC_W-1:0] rst_s_q, rst_s_d;
	logic              lrst_q, lrst_d;
	logic [SYNC_W-1:0] mode_s_q, mode_s_d;
	logic              mode_q, mode_d;
	logic [SYNC_W-1:0] ack_s_q, ack_s_d;
	logic              ack_lvl_q, ack_lvl_d;
	logic              ack_q, ack_d;

	always_comb begin
		rst_s_d   = {rst_s_q[1:0], rst};
		lrst_d    = utl2_agree(rst_s_q) ? rst_s_q[2] : lrst_q;
		mode_s_d  = {mode_s_q[1:0], mode_15phy};
		mode_d    = utl2_agree(mode_s_q) ? mode_s_q[2] : mode_q;
		ack_s_d   = {ack_s_q[1:0], ack_q};
		ack_lvl_d = utl2_agree(ack_s_q) ? ack_s_q[2] : ack_lvl_q;
	end

	// Reset reaches the link only while its clock runs; the PHY clock is free running
	always_ff @(posedge port_link_clock) begin
		rst_s_q <= rst_s_d;
		lrst_q  <= lrst_d;
		if (lrst_q) begin
			mode_s_q  <= SYNC_ZERO;
			mode_q    <= 1'b0;
			ack_s_q   <= SYNC_ZERO;
			ack_lvl_q <= 1'b0;
		end else begin
			mode_s_q  <= mode_s_d;
			mode_q    <= mode_d;
			ack_s_q   <= ack_s_d;
			ack_lvl_q <= ack_lvl_d;
		end
	end

	// ============================================================
	// Link domain: poll, select, receive
	utl2_state_t       st_q, st_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [ADDR_W-1:0] prev_q, prev_d;
	logic              pvld_q, pvld_d;
	logic [ADDR_W-1:0] sel_q, sel_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic              enb_n_q, enb_n_d;
	logic              took_q, took_d;
	logic              req_q, req_d;
	logic [WORD_W-1:0] hold_q, hold_d;
	logic              pend;

	// One byte in flight across the crossing at a time
	assign pend = (req_q != ack_lvl_q);

	always_comb begin
		st_d   = st_q;
		sel_d  = sel_q;
		cnt_d  = cnt_q;
		req_d  = req_q;
		hold_d = hold_q;
		prev_d = addr_q;
		pvld_d = (st_q == ST_POLL);
		took_d = ~enb_n_q;
		unique case (st_q)
			ST_POLL: begin
				// Cell-available answers the address driven one cycle earlier
				if (pvld_q && rx_cell_available && !pend) begin
					st_d  = ST_SEL;
					sel_d = prev_q;
				end
			end
			ST_SEL: begin
				st_d  = ST_XFER;
				cnt_d = CNT_ZERO;
			end
			ST_XFER: begin
				if (took_q) begin
					hold_d[BYTE_LSB +: BYTE_W] = rx_cell_byte_in;
					hold_d[SOC_BIT]            = rx_cell_start_flag;
					hold_d[PHY_LSB +: ADDR_W]  = sel_q;
					req_d = ~req_q;
					// Start flag realigns the byte count to the cell head
					cnt_d = rx_cell_start_flag ? CNT_FIRST : cnt_q + CNT_FIRST;
					if (cnt_d == CELL_BYTES) begin
						st_d = ST_POLL;
					end
				end
			end
		endcase
		// Pulsed enable trades throughput for a loss-free crossing
		enb_n_d = !(st_d == ST_XFER && enb_n_q && !took_q && (req_d == ack_lvl_q));
		addr_d  = (st_q == ST_POLL && st_d == ST_POLL) ? utl2_next_addr(addr_q, mode_q) : sel_d;
	end

	always_ff @(posedge port_link_clock) begin
		hold_q <= hold_d;
		if (lrst_q) begin
			st_q    <= ST_POLL;
			addr_q  <= ADDR_ZERO;
			prev_q  <= ADDR_ZERO;
			pvld_q  <= 1'b0;
			sel_q   <= ADDR_ZERO;
			cnt_q   <= CNT_ZERO;
			enb_n_q <= 1'b1;
			took_q  <= 1'b0;
			req_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			addr_q  <= addr_d;
			prev_q  <= prev_d;
			pvld_q  <= pvld_d;
			sel_q   <= sel_d;
			cnt_q   <= cnt_d;
			enb_n_q <= enb_n_d;
			took_q  <= took_d;
			req_q   <= req_d;
		end
	end

	assign rx_phy_select_addr = addr_q;
	assign rx_accept_n        = enb_n_q;

	// ============================================================
	// System domain: toggle handshake into the buffer
	logic [SYNC_W-1:0] req_s_q, req_s_d;
	logic              req_lvl_q, req_lvl_d;

	utl2_stream_if in_if ();
	utl2_stream_if out_if ();

	// Held word is stable from the toggle until the ack returns
	assign in_if.valid = (req_lvl_q != ack_q);
	assign in_if.data  = hold_q;

	always_comb begin
		req_s_d   = {req_s_q[1:0], req_q};
		req_lvl_d = utl2_agree(req_s_q) ? req_s_q[2] : req_lvl_q;
		ack_d     = (in_if.valid && in_if.ready) ? ~ack_q : ack_q;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			req_s_q   <= SYNC_ZERO;
			req_lvl_q <= 1'b0;
			ack_q     <= 1'b0;
		end else begin
			req_s_q   <= req_s_d;
			req_lvl_q <= req_lvl_d;
			ack_q     <= ack_d;
		end
	end

	utl2_buf2 u_buf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.up      (in_if.snk),
		.dn      (out_if.src)
	);

	assign out_if.ready = cell_ready;
	assign cell_valid   = out_if.valid;
	assign cell_byte    = out_if.data[BYTE_LSB +: BYTE_W];
	assign cell_start   = out_if.data[SOC_BIT];
	assign cell_phy     = out_if.data[PHY_LSB +: ADDR_W];

endmodule // utl2_rx_port

// file: verification/utl2_rx_port_assertions.sv
`timescale 1ns/1ps
// ============================================================
// Port checker
module utl2_rx_chk (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       mode_15phy,
	input wire logic       port_link_clock,
	input wire logic [3:0] rx_phy_select_addr,
	input wire logic       rx_accept_n,
	input wire logic       cell_valid,
	input wire logic       cell_ready,
	input wire logic [7:0] cell_byte,
	input wire logic       cell_start,
	input wire logic [3:0] cell_phy
);
	// ============================================================
	// Link side
	property p_pulse; @(posedge port_link_clock) disable iff (rst) !rx_accept_n |=> rx_accept_n [*3]; endproperty
	a_pulse: assert property (p_pulse) else $error("enable pulse too long");
	property p_range; @(posedge port_link_clock) disable iff (rst) rx_phy_select_addr != 4'hF; endproperty
	a_range: assert property (p_range) else $error("address 15 driven");
	property p_hold; @(posedge port_link_clock) disable iff (rst) !rx_accept_n |=> $stable(rx_phy_select_addr); endproperty
	a_hold: assert property (p_hold) else $error("address moved in transfer");
	property p_m12; @(posedge port_link_clock) disable iff (rst) !mode_15phy [*6] |-> rx_phy_select_addr <= 4'hB; endproperty
	a_m12: assert property (p_m12) else $error("address past 11");
	// Link reset lags rst by the synchroniser, hence six edges
	property p_rst; @(posedge port_link_clock) rst [*6] |-> rx_accept_n && rx_phy_select_addr == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("link side not idle");
	// ============================================================
	// User side
	property p_stand; @(posedge sys_clk) disable iff (rst)
		cell_valid && !cell_ready |=> cell_valid && $stable({cell_byte, cell_start, cell_phy}); endproperty
	a_stand: assert property (p_stand) else $error("byte lost while stalled");
	c_pop: cover property (@(posedge sys_clk) cell_valid && cell_ready && cell_start);
	c_stall: cover property (@(posedge sys_clk) cell_valid && !cell_ready);
	c_accept: cover property (@(posedge port_link_clock) !rx_accept_n);
	c_top15: cover property (@(posedge port_link_clock) rx_phy_select_addr == 4'hE);
endmodule // utl2_rx_chk

bind utl2_rx_port utl2_rx_chk u_chk (.sys_clk(sys_clk), .rst(rst), .mode_15phy(mode_15phy),
	.port_link_clock(port_link_clock), .rx_phy_select_addr(rx_phy_select_addr), .rx_accept_n(rx_accept_n),
	.cell_valid(cell_valid), .cell_ready(cell_ready), .cell_byte(cell_byte), .cell_start(cell_start),
	.cell_phy(cell_phy));

// file: verification/utl2_phy_model.sv
`timescale 1ns/1ps
// ============================================================
// One PHY device at address phy holding ncell cells
module utl2_phy_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] phy,
	input  wire logic [3:0] ncell,
	input  wire logic [3:0] addr,
	input  wire logic       accept_n,
	output logic [7:0]      byte_o,
	output logic            soc,
	output logic            clav
);
	logic [3:0] left;
	logic [5:0] k;
	logic       hold;
	always @(posedge clk) begin
		if (rst) begin
			left <= ncell;
			k <= 6'h00;
			hold <= 1'b0;
			clav <= 1'b0;
			soc <= 1'b0;
			byte_o <= 8'h5A;
		end else begin
			clav <= (addr == phy) && (left != 4'h0);
			hold <= !accept_n && (addr == phy);
			if (!accept_n && addr == phy) begin
				byte_o <= 8'(k * 4 + phy);
				soc <= (k == 6'h00);
				k <= (k == 6'h34) ? 6'h00 : k + 6'h01;
				if (k == 6'h34) left <= left - 4'h1;
			end else if (hold) begin
				// Hold time over: show the inverse so a late sample is caught
				byte_o <= ~byte_o;
				soc <= 1'b0;
			end
		end
	end
endmodule // utl2_phy_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic       sys_clk = 0;
	logic       lclk = 0;
	logic       rst = 1;
	logic       mode = 0;
	logic       ready = 0;
	logic [3:0] phy = 4'h0;
	logic [3:0] ncell = 4'h0;
	logic [3:0] addr;
	logic [3:0] cphy;
	logic [7:0] din;
	logic [7:0] cbyte;
	logic       accept_n;
	logic       soc;
	logic       clav;
	logic       valid;
	logic       cstart;
	int         fail_count = 0;
	int         checks_done = 0;
	int         cyc = 0;
	always #50 sys_clk = ~sys_clk;
	always #15 lclk = ~lclk;
	utl2_rx_port dut (.sys_clk(sys_clk), .rst(rst), .mode_15phy(mode), .port_link_clock(lclk),
		.rx_phy_select_addr(addr), .rx_accept_n(accept_n), .rx_cell_byte_in(din), .rx_cell_start_flag(soc),
		.rx_cell_available(clav), .cell_valid(valid), .cell_ready(ready), .cell_byte(cbyte),
		.cell_start(cstart), .cell_phy(cphy));
	utl2_phy_model phy_dev (.clk(lclk), .rst(rst), .phy(phy), .ncell(ncell), .addr(addr),
		.accept_n(accept_n), .byte_o(din), .soc(soc), .clav(clav));
	// ============================================================
	// Shared tasks
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task restart(input logic m, input logic [3:0] p, input logic [3:0] n);
		rst <= 1'b1;
		mode <= m;
		phy <= p;
		ncell <= n;
		ready <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
	endtask
	// Pops n bytes, holding ready low for the first stall cycles
	task get(input int n, input int stall);
		int i;
		int t;
		int w;
		i = 0;
		t = 0;
		w = 0;
		while (i < n && w < 400) begin
			@(posedge sys_clk);
			t++;
			w++;
			if (valid === 1'b1 && ready) begin
				chk(cbyte, 8'(i % 53 * 4 + phy));
				chk(8'(cstart), 8'(i % 53 == 0));
				chk(8'(cphy), 8'(phy));
				i++;
				w = 0;
			end
			ready <= (t >= stall);
		end
		chk(8'(i), 8'(n));
	endtask
	// ============================================================
	// Scenarios
	task t_stall12;
		restart(1'b0, 4'h5, 4'h1);
		get(53, 60);
	endtask
	task t_two15;
		restart(1'b1, 4'hE, 4'h2);
		get(106, 0);
	endtask
	task t_absent12;
		int seen;
		seen = 0;
		restart(1'b0, 4'hE, 4'h1);
		ready <= 1'b1;
		repeat (300) @(posedge sys_clk) seen += (valid !== 1'b0);
		chk(8'(seen), 8'h00);
	endtask
	initial begin
		t_stall12;
		t_two15;
		t_absent12;
		stop_test;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			stop_test;
		end
	end
endmodule // tb_top
